// File: srx_pkg.sv
package srx_pkg;
  // Register offsets on the plain register port
  localparam logic [1:0] ADDR_STATUS = 2'h0; // ctrl_status_first
  localparam logic [1:0] ADDR_CTRL = 2'h1; // ctrl_status_second
  localparam logic [1:0] ADDR_FORMAT = 2'h2; // ctrl_status_third
  localparam logic [1:0] ADDR_DATA = 2'h3; // data_window
  // Status field positions
  localparam int ST_PARITY_ERR = 2;
  localparam int ST_OVERRUN = 3;
  localparam int ST_FRAME_ERR = 4;
  localparam int ST_RX_COMPLETE = 7;
  // Control field positions
  localparam int CT_NINTH_BIT = 1;
  localparam int CT_RX_ENABLE = 4;
  localparam int CT_RX_IRQ_EN = 7;
  // Format field positions
  localparam int FM_DOUBLE_SPEED = 0;
  localparam int FM_SIZE_LO = 1;
  localparam int FM_STOP_BITS = 3;
  localparam int FM_PARITY_ODD = 4;
  localparam int FM_PARITY_EN = 5;
  localparam int FM_SIZE_HI = 2;
  // Reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] FORMAT_RESET = 8'h06;
  // Character size code for nine bits, and base of data sizes
  localparam logic [2:0] SIZE_NINE = 3'h7;
  localparam logic [3:0] SIZE_BASE = 4'h5;
  // Oversampling: samples per bit and vote sample numbers
  localparam logic [3:0] SPB_NORMAL = 4'hf; // 16 samples, last index
  localparam logic [3:0] SPB_DOUBLE = 4'h7; // 8 samples, last index
  localparam logic [3:0] VOTE_NORMAL = 4'h8; // samples 8, 9, 10
  localparam logic [3:0] VOTE_DOUBLE = 4'h4; // samples 4, 5, 6
  typedef enum {SRX_IDLE, SRX_START, SRX_BITS} srx_state_type;
endpackage

// File: srx_receiver.sv
`timescale 1ns/1ns
module srx_receiver (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic sample_tick_i,
  input wire logic serial_in_pin_i,
  input wire logic [1:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  output logic rx_irq_o,
  output logic pin_override_o
);
  import srx_pkg::*;

  // One buffer entry: data, ninth bit, frame, overrun and parity errors
  typedef struct packed {
    logic [7:0] data;
    logic ninth;
    logic ferr;
    logic ovr;
    logic perr;
  } srx_entry_type;

  typedef struct packed {
    logic sync_a;
    logic sync_b;
    logic line_prev;
    srx_state_type state;
    logic [3:0] sample;
    logic [3:0] bit_idx;
    logic [2:0] votes;
    logic [10:0] shreg; // Nine data bits, parity and stop
    logic shift_full;
    srx_entry_type shift_entry;
    srx_entry_type [1:0] fifo;
    logic [1:0] count;
    logic rd_ptr;
    logic wr_ptr;
    logic ovr_pending;
    logic [7:0] ctrl;
    logic [7:0] format;
    logic [7:0] rdata;
  } srx_regs_type;

  srx_regs_type r;
  srx_regs_type next_r;

  logic enabled;
  logic dbl;
  logic [3:0] last_sample;
  logic [3:0] vote_first;
  logic [2:0] size_code;
  logic [3:0] data_bits;
  logic [3:0] frame_bits;
  logic vote;
  logic rd_data;
  logic pop;
  logic push;
  logic par_calc;
  srx_entry_type head;
  srx_entry_type built;
  logic [7:0] status_val;
  logic start_seen;
  logic frame_done;

  // Configuration decode
  assign enabled = r.ctrl[CT_RX_ENABLE];
  assign dbl = r.format[FM_DOUBLE_SPEED];
  assign size_code = {r.ctrl[2], r.format[FM_SIZE_HI], r.format[FM_SIZE_LO]};
  assign last_sample = dbl ? SPB_DOUBLE : SPB_NORMAL;
  assign vote_first = dbl ? VOTE_DOUBLE : VOTE_NORMAL;
  assign data_bits = (size_code == SIZE_NINE) ? 4'h9 :
                     (size_code[2] ? 4'h8 : SIZE_BASE + {2'h0, size_code[1:0]});
  // Data plus optional parity plus the first stop bit
  assign frame_bits = data_bits + {3'h0, r.format[FM_PARITY_EN]} + 4'h1;
  assign vote = (r.votes[0] & r.votes[1]) | (r.votes[0] & r.votes[2])
              | (r.votes[1] & r.votes[2]);
  assign rd_data = reg_rd_i && (reg_addr_i == ADDR_DATA);
  assign head = r.fifo[r.rd_ptr];
  assign pop = rd_data && (r.count != 2'h0);

  // Status view of the oldest entry; error flags come from the buffer
  always_comb begin
    status_val = 8'h00;
    status_val[ST_RX_COMPLETE] = (r.count != 2'h0);
    if (r.count != 2'h0) begin
      status_val[ST_FRAME_ERR] = head.ferr;
      status_val[ST_OVERRUN] = head.ovr;
      status_val[ST_PARITY_ERR] = head.perr;
    end
    status_val[FM_DOUBLE_SPEED] = dbl;
  end

  // Frame assembled from the shift register at the first stop bit
  always_comb begin
    built = '0;
    for (int i = 0; i < 9; i++) begin
      if (4'(i) < data_bits) begin
        built.data[i % 8] = (i < 8) ? r.shreg[i] : built.data[i % 8];
      end
    end
    built.ninth = (size_code == SIZE_NINE) ? r.shreg[8] : 1'b0;
    par_calc = r.format[FM_PARITY_ODD];
    for (int i = 0; i < 9; i++) begin
      if (4'(i) < data_bits) begin
        par_calc = par_calc ^ r.shreg[i];
      end
    end
    // bits above the character size stay zero
    built.ferr = ~vote;
    built.perr = r.format[FM_PARITY_EN] && (par_calc != r.shreg[data_bits]);
    built.ovr = r.ovr_pending;
  end

  // Move the waiting frame into the buffer once a slot is free
  assign push = r.shift_full && ((r.count != 2'h2) || pop);

  // Next-state logic for the whole receiver
  always_comb begin
    next_r = r;
    next_r.sync_a = serial_in_pin_i;
    next_r.sync_b = r.sync_a;
    // Register writes; status writes are ignored
    if (reg_wr_i && reg_addr_i == ADDR_CTRL) begin
      next_r.ctrl = reg_wdata_i & 8'hfd;
    end
    if (reg_wr_i && reg_addr_i == ADDR_FORMAT) begin
      next_r.format = reg_wdata_i;
    end
    // Register reads: data one cycle later
    next_r.rdata = 8'h00;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        ADDR_STATUS: next_r.rdata = status_val;
        ADDR_CTRL: next_r.rdata = {r.ctrl[7:2], head.ninth, 1'b0};
        ADDR_FORMAT: next_r.rdata = r.format;
        ADDR_DATA: next_r.rdata = (r.count != 2'h0) ? head.data : 8'h00;
      endcase
    end
    // Buffer bookkeeping
    if (pop) begin
      next_r.rd_ptr = ~r.rd_ptr;
    end
    if (push) begin
      next_r.fifo[r.wr_ptr] = r.shift_entry;
      next_r.wr_ptr = ~r.wr_ptr;
      next_r.shift_full = 1'b0;
      next_r.ovr_pending = 1'b0;
    end
    next_r.count = r.count + {1'b0, push} - {1'b0, pop};
    // Sampling state machine
    if (sample_tick_i) begin
      next_r.line_prev = r.sync_b; // Edge compare at sample rate
      next_r.sample = r.sample + 4'h1;
      if (r.sample >= vote_first && r.sample <= vote_first + 4'h2) begin
        next_r.votes = {r.votes[1:0], r.sync_b};
      end
      unique case (r.state)
        SRX_IDLE: begin
          if (r.line_prev && !r.sync_b) begin
            next_r.state = SRX_START;
            next_r.sample = 4'h2; // this low is sample one
            if (r.count == 2'h2 && r.shift_full && !push) begin
              next_r.ovr_pending = 1'b1;
            end
          end
        end
        SRX_START: begin
          // Vote and end of bit coincide in double speed
          if (r.sample == vote_first + 4'h3 && vote) begin
            next_r.state = SRX_IDLE;
          end else if (r.sample == last_sample) begin
            next_r.state = SRX_BITS;
            next_r.sample = 4'h0;
            next_r.bit_idx = 4'h0;
          end
        end
        SRX_BITS: begin
          if (r.sample == vote_first + 4'h3) begin
            next_r.shreg[r.bit_idx] = vote;
            if (r.bit_idx + 4'h1 == frame_bits) begin
              // First stop bit decided; second stop bit ignored
              next_r.state = SRX_IDLE;
              next_r.shift_full = 1'b1;
              next_r.shift_entry = built;
            end
          end
          // Bit end checked apart from the vote
          if (r.sample == last_sample) begin
            next_r.sample = 4'h0;
            next_r.bit_idx = r.bit_idx + 4'h1;
          end
        end
      endcase
    end
    // Disable abandons reception and flushes the buffer
    if (!enabled) begin
      next_r.state = SRX_IDLE;
      next_r.count = 2'h0;
      next_r.rd_ptr = 1'b0;
      next_r.wr_ptr = 1'b0;
      next_r.shift_full = 1'b0;
      next_r.ovr_pending = 1'b0;
    end
  end

  // State register
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      r <= '0;
      r.sync_a <= 1'b1;
      r.sync_b <= 1'b1;
      r.line_prev <= 1'b1;
      r.state <= SRX_IDLE;
      r.ctrl <= CTRL_RESET;
      r.format <= FORMAT_RESET;
    end else begin
      r <= next_r;
    end
  end

  assign reg_rdata_o = r.rdata;
  assign rx_irq_o = r.ctrl[CT_RX_IRQ_EN] && (r.count != 2'h0);
  assign pin_override_o = enabled;

  // Frame events watched by the checks below
  assign start_seen = sample_tick_i && enabled && r.state == SRX_IDLE
                      && r.line_prev && !r.sync_b;
  assign frame_done = sample_tick_i && enabled && r.state == SRX_BITS
                      && r.sample == vote_first + 4'h3 && r.bit_idx + 4'h1 == frame_bits;

  irq_follows_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    r.ctrl[CT_RX_IRQ_EN] && enabled && push && !reg_wr_i |=> rx_irq_o)
    else $error("irq not raised for a stored frame");
  flush_on_disable_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !enabled |=> r.count == 2'h0)
    else $error("buffer not flushed on disable");
  disable_idle_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !enabled |=> r.state == SRX_IDLE)
    else $error("reception continued while disabled");
  count_bound_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    r.count <= 2'h2)
    else $error("buffer count exceeds two entries");
  ovr_clear_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    push |=> !r.ovr_pending)
    else $error("overrun pending not cleared on transfer");
  perr_gate_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !r.format[FM_PARITY_EN] && push |=> !r.fifo[$past(r.wr_ptr)].perr)
    else $error("parity error stored while checking off");
  err_write_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    reg_wr_i && reg_addr_i == ADDR_STATUS && !push && !pop && enabled
    |=> $stable(status_val))
    else $error("status write changed error flags");
  sync_chain_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    r.sync_b == $past(serial_in_pin_i, 2) || $past(rst_i))
    else $error("synchroniser depth wrong");
  start_seen_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    start_seen |=> r.state == SRX_START && r.sample == 4'h2)
    else $error("falling edge did not start a frame");
  spike_reject_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    sample_tick_i && enabled && r.state == SRX_START && r.sample == vote_first + 4'h3
    && vote |=> r.state == SRX_IDLE)
    else $error("spike accepted as start bit");
  ovr_set_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    start_seen && r.count == 2'h2 && r.shift_full && !push |=> r.ovr_pending)
    else $error("overrun not recorded");
  frame_store_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    frame_done |=> r.shift_full && r.state == SRX_IDLE)
    else $error("frame not held after first stop bit");
  ferr_store_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    frame_done |=> r.shift_entry.ferr == !$past(vote))
    else $error("frame error does not match stop bit");
  short_char_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    frame_done |=> (r.shift_entry.data >> $past(data_bits)) == 8'h00)
    else $error("unused data bits not zero");
  pop_advance_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    pop && !push && enabled |=> r.count == $past(r.count) - 2'h1)
    else $error("data read did not advance buffer");
  status_read_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    reg_rd_i && reg_addr_i == ADDR_STATUS
    |=> reg_rdata_o[ST_RX_COMPLETE] == ($past(r.count) != 2'h0))
    else $error("receive complete misreported");
endmodule // srx_receiver

// File: srx_remote_tx.sv
`timescale 1ns/1ns
module srx_remote_tx #(
  parameter int TICK_DIV = 4
) (
  input wire logic core_clk_i,
  output logic line_o
);
  // Idle line rests high, as its pull-up holds it
  initial line_o = 1'b1;
  // Drive one level for n sample ticks
  task automatic hold(input logic v, input int n);
    @(posedge core_clk_i);
    line_o <= v;
    repeat (n * TICK_DIV - 1) @(posedge core_clk_i);
  endtask
  // Start bit, frame bits from bit 0, then idle high
  task automatic send(input logic [11:0] f, input int n, input int spb);
    hold(1'b0, spb);
    for (int i = 0; i < n; i++) begin
      hold(f[i], spb);
    end
    hold(1'b1, spb);
  endtask
endmodule // srx_remote_tx

// File: serial_receiver_buffer_and_start_detect_bench.sv
`timescale 1ns/1ns
module serial_receiver_buffer_and_start_detect_bench;
  import srx_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic tick = 1'b0;
  logic [1:0] tick_cnt = 2'h0;
  logic line;
  logic [1:0] addr = 2'h0;
  logic [7:0] wdata = 8'h00;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic [7:0] rdata;
  logic irq;
  logic ovr_pin;
  int bad_count = 0;
  int n_tests = 0;
  int n_pop = 0;
  logic [8:0] d;
  logic [8:0] q [4];
  logic [7:0] v;
  // Clock and a sample tick every fourth cycle
  always #4 clk = ~clk;
  always @(posedge clk) begin
    tick_cnt <= tick_cnt + 2'h1;
    tick <= (tick_cnt == 2'h3);
  end
  srx_remote_tx #(.TICK_DIV(4)) U_TX (.core_clk_i(clk), .line_o(line));
  srx_receiver DUT (.core_clk_i(clk), .rst_i(rst), .sample_tick_i(tick),
    .serial_in_pin_i(line), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_rdata_o(rdata),
    .rx_irq_o(irq), .pin_override_o(ovr_pin));
  // Verdict and end of run
  task automatic conclude();
    $display("Checks %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Register port cycles
  task automatic wr(input logic [1:0] a, input logic [7:0] w);
    @(posedge clk);
    addr <= a;
    wdata <= w;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [1:0] a, output logic [7:0] r);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 r = rdata;
  endtask
  // Frame bits: data, optional parity, first stop bit
  function automatic logic [11:0] fb(input logic [8:0] x, input int n,
      input logic pe, input logic p, input logic st);
    logic [11:0] f;
    f = 12'h000;
    for (int i = 0; i < n; i++) f[i] = x[i];
    if (pe) f[n] = p;
    f[n + int'(pe)] = st;
    return f;
  endfunction
  task automatic rx(input logic [8:0] x, input int n, input logic pe,
      input logic p, input logic st, input int spb);
    U_TX.send(fb(x, n, pe, p, st), n + int'(pe) + 1, spb);
    repeat (8) @(posedge clk);
  endtask
  // Status before data, as software must
  task automatic entry(input logic [7:0] est, input logic [7:0] ed);
    rd(ADDR_STATUS, v);
    chk(v, est);
    rd(ADDR_DATA, v);
    chk(v, ed);
  endtask
  // Hang guard
  initial begin
    #700000;
    bad_count++;
    conclude();
  end
  // Main sequence
  initial begin
    void'($urandom(41));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rd(ADDR_CTRL, v);
    chk(v, CTRL_RESET);
    rd(ADDR_FORMAT, v);
    chk(v, FORMAT_RESET);
    rd(ADDR_STATUS, v);
    chk(v, 8'h00);
    wr(ADDR_CTRL, 8'h90);
    chk({7'h0, ovr_pin}, 8'h01);
    // Both sample rates; interrupt follows receive-complete
    for (int s = 0; s < 2; s++) begin
      wr(ADDR_FORMAT, FORMAT_RESET | 8'(s));
      d = 9'($urandom);
      rx(d, 8, 1'b0, 1'b0, 1'b1, 16 >> s);
      chk({7'h0, irq}, 8'h01);
      entry(8'h80 | 8'(s), d[7:0]);
      chk({7'h0, irq}, 8'h00);
    end
    // Even and odd parity, good and bad
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_FORMAT, k[0] ? 8'h36 : 8'h26);
      d = 9'($urandom);
      rx(d, 8, 1'b1, ^d[7:0] ^ k[0] ^ k[1], 1'b1, 16);
      entry(k[1] ? 8'h84 : 8'h80, d[7:0]);
    end
    // Low stop bit with two stop bits set; status write must not clear it
    wr(ADDR_FORMAT, FORMAT_RESET | 8'h08);
    d = 9'($urandom);
    rx(d, 8, 1'b0, 1'b0, 1'b0, 16);
    U_TX.hold(1'b1, 32);
    wr(ADDR_STATUS, 8'h00);
    chk({7'h0, irq}, 8'h01);
    entry(8'h90, d[7:0]);
    // Five-bit and nine-bit characters
    wr(ADDR_FORMAT, 8'h00);
    d = 9'($urandom);
    rx(d, 5, 1'b0, 1'b0, 1'b1, 16);
    entry(8'h80, {3'h0, d[4:0]});
    wr(ADDR_FORMAT, FORMAT_RESET);
    wr(ADDR_CTRL, 8'h94);
    d = 9'($urandom);
    rx(d, 9, 1'b0, 1'b0, 1'b1, 16);
    rd(ADDR_CTRL, v);
    chk(v, 8'h94 | {6'h0, d[8], 1'b0});
    entry(8'h80, d[7:0]);
    wr(ADDR_CTRL, 8'h90);
    // Four frames unread: third lost in shifter, fourth carries overrun
    for (int i = 0; i < 4; i++) begin
      q[i] = 9'($urandom);
      rx(q[i], 8, 1'b0, 1'b0, 1'b1, 16);
    end
    for (int i = 0; i < 3; i++) begin
      entry(i == 2 ? 8'h88 : 8'h80, q[(i == 2) ? 3 : i][7:0]);
    end
    rd(ADDR_STATUS, v);
    chk(v, 8'h00);
    // First of two fresh frames carries no overrun; drain by reading data
    rx(d, 8, 1'b0, 1'b0, 1'b1, 16);
    rx(d, 8, 1'b0, 1'b0, 1'b1, 16);
    n_pop = 0;
    for (int i = 0; i < 4; i++) begin
      rd(ADDR_STATUS, v);
      if (i == 0) begin
        chk(v, 8'h80);
      end
      if (v[ST_RX_COMPLETE] === 1'b1) begin
        rd(ADDR_DATA, v);
        n_pop++;
      end
    end
    chk(8'(n_pop), 8'h02);
    rd(ADDR_STATUS, v);
    chk(v, 8'h00);
    // Short spike is rejected
    U_TX.hold(1'b0, 3);
    U_TX.hold(1'b1, 40);
    rd(ADDR_STATUS, v);
    chk(v, 8'h00);
    // Disable flushes the buffer
    rx(d, 8, 1'b0, 1'b0, 1'b1, 16);
    wr(ADDR_CTRL, 8'h00);
    chk({6'h0, ovr_pin, irq}, 8'h00);
    rd(ADDR_STATUS, v);
    chk(v, 8'h00);
    // Disable mid-frame drops the partial frame
    wr(ADDR_CTRL, 8'h90);
    U_TX.hold(1'b0, 48);
    wr(ADDR_CTRL, 8'h00);
    wr(ADDR_CTRL, 8'h90);
    U_TX.hold(1'b1, 200);
    rd(ADDR_STATUS, v);
    chk(v, 8'h00);
    conclude();
  end
endmodule // serial_receiver_buffer_and_start_detect_bench
